/* testbench/ppas_properties.sv */
// concurrent checks on the ports of the port pin analog input select block
`timescale 1ns/100ps
module ppas_properties
    import ppas_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  pin_analog_switch,
    input wire logic        even_pin_channel,
    input wire logic        odd_pin_channel,
    input wire logic [2:0]  conv_pos_src,
    input wire logic [2:0]  conv_neg_src,
    input wire logic        amp_enable,
    input wire logic [3:0]  amplifier_gain_field
);
    // --------------------------------------------------------------
    // access sequences and properties
    // --------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence wr_s(a, c);
        psel && penable && pwrite && paddr == a && c;
    endsequence
    sequence rd_s(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    // decode kept apart so a refused address is judged on its own
    logic mapped;
    assign mapped = paddr inside {PPAS_OFF_PIN_SEL, PPAS_OFF_MUX_CFG, PPAS_OFF_CHAN_SEL, PPAS_OFF_AMP_CTL,
                                  PPAS_OFF_STATUS};
    // pin register lands on the write edge, switches one edge later
    property sw_wr_p;
        wr_s(PPAS_OFF_PIN_SEL, 1'b1) |-> ##2 pin_analog_switch == $past(pwdata[7:0], 2);
    endproperty
    // channel register lands on the write edge, routing one edge later
    property pos_amp_p;
        wr_s(PPAS_OFF_CHAN_SEL, pwdata[3:0] == PPAS_CH_AMP) |-> ##2 conv_pos_src == PPAS_SRC_AMP;
    endproperty
    AST_READY: assert property (pready) else $error("pready low");
    AST_SW_WR: assert property (sw_wr_p)
        else $error("pin switches do not follow write");
    AST_EVEN_OR: assert property (even_pin_channel == |(pin_analog_switch & 8'h55))
        else $error("even channel not or of even pins");
    AST_ODD_OR: assert property (odd_pin_channel == |(pin_analog_switch & 8'haa))
        else $error("odd channel not or of odd pins");
    AST_AMP_EN: assert property (wr_s(PPAS_OFF_AMP_CTL, 1'b1) |=>
        amp_enable == $past(pwdata[7])) else $error("amp enable not written");
    AST_GAIN: assert property (wr_s(PPAS_OFF_AMP_CTL, 1'b1) |=>
        amplifier_gain_field == $past(pwdata[3:0])) else $error("gain field not written");
    AST_POS_AMP: assert property (pos_amp_p)
        else $error("amp not on positive input");
    AST_SLVERR: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_RD_PIN: assert property (rd_s(PPAS_OFF_PIN_SEL) |-> prdata == {24'h0, pin_analog_switch})
        else $error("pin select readback wrong");
endmodule // ppas_properties
bind ppas_top ppas_properties u_props (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_analog_switch, .even_pin_channel, .odd_pin_channel, .conv_pos_src, .conv_neg_src, .amp_enable,
    .amplifier_gain_field);

/* testbench/ppas_top_tb.sv */
// self-checking testbench for the port pin analog input select block
`timescale 1ns/100ps
module ppas_top_tb
    import ppas_pkg::*;
;
    // --------------------------------------------------------------
    // stimulus, checks and scenarios
    // --------------------------------------------------------------
    logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
    logic [7:0]  paddr = 8'h00, pin_analog_switch;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        even_pin_channel, odd_pin_channel, amp_enable;
    logic [2:0]  conv_pos_src, conv_neg_src;
    logic [3:0]  amplifier_gain_field;
    int          err_total = 0, n_checks = 0;
    ppas_top dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_analog_switch, .even_pin_channel, .odd_pin_channel, .conv_pos_src, .conv_neg_src, .amp_enable,
        .amplifier_gain_field);
    // free running 200 mhz clock
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no cycle budget here: only the watchdog ends a hung wait
        while (pready !== 1'b1)
            @(posedge mclk);
        chk(pready, 1'b1, "no pready");
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // write then let the two-stage switch path settle
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        repeat (4) @(posedge mclk);
    endtask
    task t_reset;
        logic [7:0] regs [4];
        regs = '{PPAS_OFF_PIN_SEL, PPAS_OFF_MUX_CFG, PPAS_OFF_CHAN_SEL, PPAS_OFF_AMP_CTL};
        foreach (regs[i])
        begin
            xfer(regs[i], 1'b0, 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        chk(conv_pos_src, PPAS_SRC_OTHER, "pos src after reset");
        chk(pin_analog_switch, 8'h00, "switches after reset");
    endtask
    task t_pins;
        logic [7:0] v [4];
        v = '{8'hff, 8'h5a, 8'ha0, 8'h05};
        for (int i = 0; i < 8; i++)
        begin
            wr(PPAS_OFF_PIN_SEL, 32'h1 << i);
            chk(pin_analog_switch, 8'h01 << i, "single pin");
            chk({odd_pin_channel, even_pin_channel}, (i % 2) ? 2'b10 : 2'b01, "parity channel");
        end
        foreach (v[i])
        begin
            wr(PPAS_OFF_PIN_SEL, {24'hffffff, v[i]});
            xfer(PPAS_OFF_PIN_SEL, 1'b0, 32'h0);
            chk(rd, {24'h0, v[i]}, "pin readback");
            chk({odd_pin_channel, even_pin_channel}, {|(v[i] & 8'haa), |(v[i] & 8'h55)}, "wired or");
        end
    endtask
    task t_amp;
        wr(PPAS_OFF_MUX_CFG, 32'h0);
        wr(PPAS_OFF_CHAN_SEL, PPAS_CH_AMP);
        chk({conv_pos_src, conv_neg_src}, {PPAS_SRC_AMP, PPAS_SRC_NONE}, "amp single");
        wr(PPAS_OFF_MUX_CFG, 32'h4);
        chk({conv_pos_src, conv_neg_src}, {PPAS_SRC_AMP, PPAS_SRC_AMP_REF}, "amp differential");
        for (int g = 0; g < 16; g++)
        begin
            wr(PPAS_OFF_AMP_CTL, 32'h80 | g);
            chk({amp_enable, amplifier_gain_field}, 5'h10 | g, "gain code");
        end
        wr(PPAS_OFF_AMP_CTL, 32'h7f);
        xfer(PPAS_OFF_AMP_CTL, 1'b0, 32'h0);
        chk(rd, 32'h0f, "reserved amp bits");
        chk(amp_enable, 1'b0, "amp disabled");
    endtask
    task t_pair;
        wr(PPAS_OFF_PIN_SEL, 32'h02);
        wr(PPAS_OFF_MUX_CFG, 32'h0);
        wr(PPAS_OFF_CHAN_SEL, PPAS_CH_EVEN);
        chk({conv_pos_src, conv_neg_src}, {PPAS_SRC_EVEN, PPAS_SRC_NONE}, "even single");
        wr(PPAS_OFF_CHAN_SEL, PPAS_CH_ODD);
        chk({conv_pos_src, conv_neg_src}, {PPAS_SRC_ODD, PPAS_SRC_NONE}, "odd single");
        wr(PPAS_OFF_MUX_CFG, 32'h8);
        wr(PPAS_OFF_CHAN_SEL, PPAS_CH_EVEN);
        xfer(PPAS_OFF_STATUS, 1'b0, 32'h0);
        chk(rd, {24'h0, PPAS_SRC_EVEN, PPAS_SRC_ODD, 2'b10}, "pair status");
        wr(PPAS_OFF_CHAN_SEL, PPAS_CH_ODD);
        chk(conv_pos_src, PPAS_SRC_EVEN, "pair odd code");
    endtask
    task t_bad;
        xfer(8'h10, 1'b1, 32'hff);
        chk(se, 1'b1, "unmapped write flagged");
        xfer(8'h10, 1'b0, 32'h0);
        chk(se, 1'b1, "unmapped read flagged");
        chk(rd, 32'h0, "unmapped reads zero");
        xfer(PPAS_OFF_PIN_SEL, 1'b0, 32'h0);
        chk(rd, 32'h02, "pins untouched");
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({pin_analog_switch, conv_pos_src}, 11'h0, "mid-run reset");
        rstn <= 1'b1;
        xfer(PPAS_OFF_PIN_SEL, 1'b0, 32'h0);
        chk(rd, 32'h0, "pins after reset");
        chk(conv_pos_src, PPAS_SRC_OTHER, "pos src after mid-run reset");
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_reset;
        t_pins;
        t_amp;
        t_pair;
        t_bad;
        report_and_stop;
    end
    // watchdog, well past the few hundred cycles the run needs
    initial
    begin
        #50000;
        err_total++;
        report_and_stop;
    end
endmodule // ppas_top_tb

/* verilog/ppas_pin_route.sv */
// pin switch router: per-pin switch enables and parity channel merge
`timescale 1ns/100ps
module ppas_pin_route
    import ppas_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rstn,
    ppas_sel_if.route  sel
);
    // ------------------------------------------------------------
    // switch enables, registered so switches never glitch
    // ------------------------------------------------------------
    logic [7:0] sw_q;
    logic       even_q;
    logic       odd_q;
    logic       pair_q;

    // one switch per pin, bit n drives pin n
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            sw_q <= 8'h00;
        else
            sw_q <= sel.pin_sel;
    end

    // wired-or of same-parity pins forms the two channels
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            even_q <= 1'b0;
            odd_q  <= 1'b0;
            pair_q <= 1'b0;
        end
        else
        begin
            even_q <= |{sel.pin_sel[6], sel.pin_sel[4], sel.pin_sel[2], sel.pin_sel[0]};
            odd_q  <= |{sel.pin_sel[7], sel.pin_sel[5], sel.pin_sel[3], sel.pin_sel[1]};
            pair_q <= sel.pair_cfg;
        end
    end

    assign sel.pin_to_mux  = sw_q;
    assign sel.even_active = even_q;
    assign sel.odd_active  = odd_q;
    assign sel.pair_mode   = pair_q;
endmodule // ppas_pin_route

/* verilog/ppas_pkg.sv */
// package for the port pin analog input select block
package ppas_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the apb)
    // ------------------------------------------------------------
    localparam logic [7:0]  PPAS_OFF_PIN_SEL   = 8'hba;
    localparam logic [7:0]  PPAS_OFF_MUX_CFG   = 8'hb8;
    localparam logic [7:0]  PPAS_OFF_CHAN_SEL  = 8'hbc;
    localparam logic [7:0]  PPAS_OFF_AMP_CTL   = 8'hd6;
    localparam logic [7:0]  PPAS_OFF_STATUS    = 8'hc0;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PPAS_RST_PIN_SEL   = 8'h00;
    localparam logic [3:0]  PPAS_RST_MUX_CFG   = 4'h0;
    localparam logic [3:0]  PPAS_RST_CHAN_SEL  = 4'h0;
    localparam logic [7:0]  PPAS_RST_AMP_CTL   = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          PPAS_CFG_PAIR_BIT  = 3;   // port pair config
    localparam int          PPAS_CFG_AMPD_BIT  = 2;   // amplifier differential
    localparam int          PPAS_AMP_EN_BIT    = 7;
    localparam int          PPAS_AMP_GAIN_MSB  = 3;
    localparam int          PPAS_AMP_GAIN_LSB  = 0;
    // ------------------------------------------------------------
    // selector channel codes (channel select register)
    // ------------------------------------------------------------
    localparam logic [3:0]  PPAS_CH_AMP        = 4'h4;
    localparam logic [3:0]  PPAS_CH_EVEN       = 4'h6;
    localparam logic [3:0]  PPAS_CH_ODD        = 4'h7;
    // ------------------------------------------------------------
    // converter input sources
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PPAS_SRC_NONE      = 3'h0,
        PPAS_SRC_EVEN      = 3'h1,
        PPAS_SRC_ODD       = 3'h2,
        PPAS_SRC_AMP       = 3'h3,
        PPAS_SRC_AMP_REF   = 3'h4,
        PPAS_SRC_OTHER     = 3'h5
    } ppas_src_t;
endpackage

/* verilog/ppas_sel_if.sv */
// interface carrying pin selection state from register file to router
`timescale 1ns/100ps
interface ppas_sel_if;
    logic [7:0] pin_sel;
    logic       pair_cfg;
    logic [7:0] pin_to_mux;
    logic       even_active;
    logic       odd_active;
    logic       pair_mode;
    modport regs  (output pin_sel, output pair_cfg, input pin_to_mux, input even_active, input odd_active,
                   input pair_mode);
    modport route (input pin_sel, input pair_cfg, output pin_to_mux, output even_active, output odd_active,
                   output pair_mode);
endinterface

/* verilog/ppas_top.sv */
// port pin analog input select block with apb register access
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module ppas_top
    import ppas_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  pin_analog_switch,
    output logic             even_pin_channel,
    output logic             odd_pin_channel,
    output logic      [2:0]  conv_pos_src,
    output logic      [2:0]  conv_neg_src,
    output logic             amp_enable,
    output logic      [3:0]  amplifier_gain_field
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  pin_sel_q;
    logic [3:0]  mux_cfg_q;
    logic [3:0]  chan_sel_q;
    logic [7:0]  amp_ctl_q;
    logic [31:0] rdata_q;
    logic        slverr_q;
    logic [2:0]  pos_q;
    logic [2:0]  neg_q;
    logic        wr_en;
    logic        rd_en;
    logic        wr_pin_sel;
    logic        wr_mux_cfg;
    logic        wr_chan_sel;
    logic        wr_amp_ctl;
    logic        amp_diff;
    logic [7:0]  status_word;

    // carries the selection from the register file to the pin router
    ppas_sel_if sel ();

    // decode that both write and read paths use
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == PPAS_OFF_PIN_SEL)
                  || (a == PPAS_OFF_MUX_CFG)
                  || (a == PPAS_OFF_CHAN_SEL)
                  || (a == PPAS_OFF_AMP_CTL)
                  || (a == PPAS_OFF_STATUS);
    endfunction

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign pready = 1'b1;   // every access finishes in its first access cycle
    // a write to the read-only status word is taken but changes nothing
    assign wr_en  = psel && penable && pwrite && addr_known(paddr);
    assign rd_en  = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // per-register write strobes
    // ------------------------------------------------------------
    // one strobe per register keeps the register processes free of address compares
    assign wr_pin_sel  = wr_en && (paddr == PPAS_OFF_PIN_SEL);
    assign wr_mux_cfg  = wr_en && (paddr == PPAS_OFF_MUX_CFG);
    assign wr_chan_sel = wr_en && (paddr == PPAS_OFF_CHAN_SEL);
    assign wr_amp_ctl  = wr_en && (paddr == PPAS_OFF_AMP_CTL);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // pin selection register
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            pin_sel_q <= PPAS_RST_PIN_SEL;
        else if (wr_pin_sel)
            pin_sel_q <= pwdata[7:0];
    end

    // selector configuration, upper bits unused
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            mux_cfg_q <= PPAS_RST_MUX_CFG;
        else if (wr_mux_cfg)
            mux_cfg_q <= pwdata[3:0];
    end

    // channel select
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            chan_sel_q <= PPAS_RST_CHAN_SEL;
        else if (wr_chan_sel)
            chan_sel_q <= pwdata[3:0];
    end

    // amplifier control; bits 6-4 reserved and held at zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            amp_ctl_q <= PPAS_RST_AMP_CTL;
        else if (wr_amp_ctl)
            amp_ctl_q <= {pwdata[PPAS_AMP_EN_BIT], 3'h0, pwdata[PPAS_AMP_GAIN_MSB:PPAS_AMP_GAIN_LSB]};
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // live routing state, so software sees what the switches really do
    assign status_word = {pos_q, neg_q, sel.odd_active, sel.even_active};

    // read data registered in setup, valid through the access cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            slverr_q <= !addr_known(paddr);
            rdata_q  <= 32'h0000_0000;
            if (rd_en)
            begin
                unique case (paddr)
                    PPAS_OFF_PIN_SEL:  rdata_q <= {24'h000000, pin_sel_q};
                    PPAS_OFF_MUX_CFG:  rdata_q <= {28'h0000000, mux_cfg_q};
                    PPAS_OFF_CHAN_SEL: rdata_q <= {28'h0000000, chan_sel_q};
                    PPAS_OFF_AMP_CTL:  rdata_q <= {24'h000000, amp_ctl_q};
                    PPAS_OFF_STATUS:   rdata_q <= {24'h000000, status_word};
                    default:           rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata  = rdata_q;
    assign pslverr = psel && penable && slverr_q;

    // ------------------------------------------------------------
    // pin router
    // ------------------------------------------------------------
    assign sel.pin_sel  = pin_sel_q;
    assign sel.pair_cfg = mux_cfg_q[PPAS_CFG_PAIR_BIT];

    ppas_pin_route u_route
    (
        .mclk (mclk),
        .rstn (rstn),
        .sel  (sel)
    );

    // ------------------------------------------------------------
    // converter input routing
    // ------------------------------------------------------------
    // amplifier differential mode bit of the selector configuration
    assign amp_diff = mux_cfg_q[PPAS_CFG_AMPD_BIT];

    // registered so the analog switches change only on a clock edge;
    // the cost is one extra cycle before a new channel reaches the converter
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pos_q <= PPAS_SRC_NONE;
            neg_q <= PPAS_SRC_NONE;
        end
        else
        begin
            unique case (chan_sel_q)
                PPAS_CH_AMP:
                begin
                    pos_q <= PPAS_SRC_AMP;
                    neg_q <= amp_diff ? PPAS_SRC_AMP_REF : PPAS_SRC_NONE;
                end
                PPAS_CH_EVEN:
                begin
                    pos_q <= PPAS_SRC_EVEN;
                    neg_q <= sel.pair_mode ? PPAS_SRC_ODD : PPAS_SRC_NONE;
                end
                PPAS_CH_ODD:
                begin
                    pos_q <= sel.pair_mode ? PPAS_SRC_EVEN : PPAS_SRC_ODD;
                    neg_q <= PPAS_SRC_NONE;
                end
                default:
                begin
                    // other selector inputs lie outside this block
                    pos_q <= PPAS_SRC_OTHER;
                    neg_q <= PPAS_SRC_NONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output below comes straight from a flip-flop, so the
    // analog side never sees a decode glitch
    assign conv_pos_src         = pos_q;
    assign conv_neg_src         = neg_q;
    assign pin_analog_switch    = sel.pin_to_mux;
    assign even_pin_channel     = sel.even_active;
    assign odd_pin_channel      = sel.odd_active;
    assign amp_enable           = amp_ctl_q[PPAS_AMP_EN_BIT];
    assign amplifier_gain_field = amp_ctl_q[PPAS_AMP_GAIN_MSB:PPAS_AMP_GAIN_LSB];
endmodule // ppas_top
